// ### rtl/apsr_axis.v
`timescale 1ns/1ns
`default_nettype none
`include "apsr_regs.vh"
module apsr_axis #(
  parameter IS_U_AXIS = 0
) (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rdata_r,
  input  wire [15:0] correction_speed_step,
  input  wire [11:0] speed_magnification_setting,
  input  wire [15:0] high_speed_step,
  input  wire [15:0] low_speed_step,
  input  wire [3:0]  index_count_setting,
  input  wire [2:0]  idle_count_setting,
  input  wire        slowdown_manual_select,
  input  wire        pulser_mode,
  input  wire        circular_mode,
  input  wire        linear2_mode,
  input  wire        correction_run,
  input  wire        start_req,
  input  wire        stop_req,
  input  wire        encoder_index_input,
  output reg         pulse_out_r,
  output reg         correction_pulse_r,
  output reg         busy_r,
  output reg         decel_r
);
  // ****************************************************************
  // state and storage
  // ****************************************************************
  localparam ST_IDLE  = 2'b00;
  localparam ST_ACCEL = 2'b01;
  localparam ST_RUN   = 2'b10;
  localparam ST_DECEL = 2'b11;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [31:0] feed_amount_r;
  reg  [31:0] feed_amount_pre_r;
  reg  [31:0] circle_centre_r;
  reg  [31:0] circle_centre_pre_r;
  reg  [31:0] circular_step_count_r;
  reg  [31:0] circular_step_count_pre_r;
  reg  [31:0] slowdown_point_r;
  reg  [31:0] slowdown_point_pre_r;
  reg  [31:0] remaining_r;
  reg  [31:0] circ_left_r;
  reg  [31:0] accel_pulses_r;
  reg  [15:0] speed_r;
  reg  [3:0]  index_cnt_r;
  reg  [2:0]  idle_cnt_r;
  reg  [31:0] rd_mux;
  wire        out_tick;
  wire        corr_tick;
  wire [31:0] sdc_value;
  wire        decel_now;
  wire [31:0] cmp_remain;
  wire [31:0] load_amount;
  wire [31:0] feed_mag;
  wire [15:0] shown_speed;
  wire        running;

  assign running = (state_r != ST_IDLE);

  // ****************************************************************
  // rate generators
  // ****************************************************************
  // output pulse train at the current speed step
  apsr_rate_gen u_out_rate (
    .clk_sys (clk_sys),
    .srst    (srst),
    .en      (running),
    .step    (speed_r),
    .mag     (speed_magnification_setting),
    .tick_r  (out_tick)
  );

  // correction / reverse speed pulse train
  apsr_rate_gen u_corr_rate (
    .clk_sys (clk_sys),
    .srst    (srst),
    .en      (correction_run),
    .step    (correction_speed_step),
    .mag     (speed_magnification_setting),
    .tick_r  (corr_tick)
  );

  // ****************************************************************
  // slow-down decision
  // ****************************************************************
  // circular moves on non-U axes judge slow-down by steps left on the circle
  assign cmp_remain = (circular_mode && IS_U_AXIS == 0) ?
                      circ_left_r : remaining_r;

  apsr_slowdown_cmp u_sd (
    .manual_sel (slowdown_manual_select),
    .slowdown   (slowdown_point_r),
    .auto_point (accel_pulses_r),
    .remaining  (cmp_remain),
    .active     (running),
    .calc_value (sdc_value),
    .decel_now  (decel_now)
  );

  // travel magnitude; linear-2 takes the major axis from the centre
  assign load_amount = linear2_mode ? circle_centre_pre_r
                                    : feed_amount_pre_r;
  assign feed_mag    = load_amount[31] ? (32'h0000_0000 - load_amount)
                                       : load_amount;

  // ****************************************************************
  // profile state machine
  // ****************************************************************
  // accel to high, hold, decel to low, then run at low to zero
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req && feed_mag != 32'h0000_0000)
          state_nxt = ST_ACCEL;
      end
      ST_ACCEL: begin
        if (decel_now)
          state_nxt = ST_DECEL;
        else if (speed_r >= high_speed_step)
          state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (decel_now)
          state_nxt = ST_DECEL;
      end
      ST_DECEL: begin
        state_nxt = ST_DECEL;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (running && (stop_req ||
        (out_tick && remaining_r == 32'h0000_0001)))
      state_nxt = ST_IDLE;
  end

  // ****************************************************************
  // register writes, pre-register transfer and counters
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      state_r                   <= ST_IDLE;
      feed_amount_r             <= `APSR_RST_WORD;
      feed_amount_pre_r         <= `APSR_RST_WORD;
      circle_centre_r           <= `APSR_RST_WORD;
      circle_centre_pre_r       <= `APSR_RST_WORD;
      circular_step_count_r     <= `APSR_RST_WORD;
      circular_step_count_pre_r <= `APSR_RST_WORD;
      slowdown_point_r          <= `APSR_RST_WORD;
      slowdown_point_pre_r      <= `APSR_RST_WORD;
      remaining_r               <= `APSR_RST_WORD;
      circ_left_r               <= `APSR_RST_WORD;
      accel_pulses_r            <= `APSR_RST_WORD;
      speed_r                   <= 16'h0000;
      index_cnt_r               <= 4'h0;
      idle_cnt_r                <= 3'h0;
    end else begin
      state_r <= state_nxt;
      // pre-registers and live registers take host writes
      if (wr_en) begin
        case (addr)
          `APSR_OFS_FEED_PRE:     feed_amount_pre_r    <= wdata;
          `APSR_OFS_CENTRE_PRE:   circle_centre_pre_r  <= wdata;
          `APSR_OFS_SLOWDOWN_PRE: slowdown_point_pre_r <= wdata;
          `APSR_OFS_CIRC_STEP_PRE: begin
            if (IS_U_AXIS == 0)
              circular_step_count_pre_r <= wdata;
          end
          `APSR_OFS_FEED:     feed_amount_r    <= wdata;
          `APSR_OFS_CENTRE:   circle_centre_r  <= wdata;
          `APSR_OFS_SLOWDOWN: slowdown_point_r <= wdata;
          `APSR_OFS_CIRC_STEP: begin
            if (IS_U_AXIS == 0)
              circular_step_count_r <= wdata;
          end
          default: begin
          end
        endcase
      end
      if (state_r == ST_IDLE) begin
        speed_r <= 16'h0000;
        if (start_req && feed_mag != 32'h0000_0000) begin
          // start copies every pre-register into its live register; the U axis loads zero into its circular step count
          feed_amount_r         <= feed_amount_pre_r;
          circle_centre_r       <= circle_centre_pre_r;
          slowdown_point_r      <= slowdown_point_pre_r;
          circular_step_count_r <= (IS_U_AXIS == 0) ?
                                   circular_step_count_pre_r
                                   : `APSR_RST_WORD;
          circ_left_r    <= (IS_U_AXIS == 0) ?
                            circular_step_count_pre_r : `APSR_RST_WORD;
          remaining_r    <= feed_mag;
          accel_pulses_r <= `APSR_RST_WORD;
          speed_r        <= low_speed_step;
          index_cnt_r    <= index_count_setting;
          idle_cnt_r     <= idle_count_setting;
        end
      end else if (state_nxt == ST_IDLE) begin
        speed_r     <= 16'h0000;
        remaining_r <= `APSR_RST_WORD;
        // the closing pulse still counts down the circle
        if (out_tick && circ_left_r != 32'h0000_0000)
          circ_left_r <= circ_left_r - 32'h0000_0001;
      end else begin
        if (out_tick) begin
          remaining_r <= remaining_r - 32'h0000_0001;
          if (circ_left_r != 32'h0000_0000)
            circ_left_r <= circ_left_r - 32'h0000_0001;
          if (idle_cnt_r != 3'h0)
            idle_cnt_r <= idle_cnt_r - 3'h1;
          // idling pulses run at low speed before ramping
          if (state_r == ST_ACCEL && idle_cnt_r == 3'h0) begin
            accel_pulses_r <= accel_pulses_r + 32'h0000_0001;
            if (speed_r < high_speed_step)
              speed_r <= speed_r + 16'h0001;
          end
          // ramp down, then hold at low speed until the end
          if (state_r == ST_DECEL && speed_r > low_speed_step)
            speed_r <= speed_r - 16'h0001;
        end
        if (encoder_index_input && index_cnt_r != 4'h0)
          index_cnt_r <= index_cnt_r - 4'h1;
      end
    end
  end

  // ****************************************************************
  // read data path
  // ****************************************************************
  // while running, pulser mode shows the set high speed, not the live one; stopped shows zero
  assign shown_speed = !running ? 16'h0000 :
                       pulser_mode ? high_speed_step : speed_r;

  always @* begin
    rd_mux = `APSR_RST_WORD;
    case (addr)
      `APSR_OFS_LIVE: begin
        rd_mux[`APSR_SPD_MSB:`APSR_SPD_LSB]   = shown_speed;
        rd_mux[`APSR_IDX_MSB:`APSR_IDX_LSB]   = index_cnt_r;
        rd_mux[`APSR_IDLE_MSB:`APSR_IDLE_LSB] = idle_cnt_r;
      end
      `APSR_OFS_FEED:          rd_mux = feed_amount_r;
      `APSR_OFS_FEED_PRE:      rd_mux = feed_amount_pre_r;
      `APSR_OFS_CENTRE:        rd_mux = circle_centre_r;
      `APSR_OFS_CENTRE_PRE:    rd_mux = circle_centre_pre_r;
      `APSR_OFS_SLOWDOWN:      rd_mux = slowdown_point_r;
      `APSR_OFS_SLOWDOWN_PRE:  rd_mux = slowdown_point_pre_r;
      `APSR_OFS_CIRC_STEP:     rd_mux = circular_step_count_r;
      `APSR_OFS_CIRC_STEP_PRE: rd_mux = circular_step_count_pre_r;
      `APSR_OFS_CIRC_STEP_CNT: rd_mux = circ_left_r;
      `APSR_OFS_SDC:           rd_mux = sdc_value;
      `APSR_OFS_REMAIN:        rd_mux = remaining_r;
      default:                 rd_mux = `APSR_RST_WORD;
    endcase
  end

  // registered outputs; bits 31:23 of the live word stay zero
  always @(posedge clk_sys) begin
    if (srst) begin
      rdata_r            <= `APSR_RST_WORD;
      pulse_out_r        <= 1'b0;
      correction_pulse_r <= 1'b0;
      busy_r             <= 1'b0;
      decel_r            <= 1'b0;
    end else begin
      if (rd_en)
        rdata_r <= rd_mux;
      pulse_out_r        <= out_tick && running;
      correction_pulse_r <= corr_tick;
      busy_r             <= (state_nxt != ST_IDLE);
      decel_r            <= (state_nxt == ST_DECEL);
    end
  end
endmodule // apsr_axis
`default_nettype wire

// ### rtl/apsr_rate_gen.v
`timescale 1ns/1ns
`default_nettype none
`include "apsr_regs.vh"
// step rate generator: tick rate = step * fclk / ((mag + 1) * 65536)
module apsr_rate_gen (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        en,
  input  wire [15:0] step,
  input  wire [11:0] mag,
  output reg         tick_r
);
  reg  [11:0] pre_r;
  reg  [15:0] acc_r;
  wire [16:0] sum;
  wire        pre_done;

  assign pre_done = (pre_r == mag);
  assign sum      = {1'b0, acc_r} + {1'b0, step};

  // prescaler by mag+1, then 16-bit phase accumulator
  always @(posedge clk_sys) begin
    if (srst || !en) begin
      pre_r  <= 12'h000;
      acc_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (pre_done) begin
        pre_r  <= 12'h000;
        acc_r  <= sum[15:0];
        tick_r <= sum[`APSR_ACC_FULL_BITS]; // carry out = one pulse
      end else begin
        pre_r <= pre_r + 12'h001;
      end
    end
  end
endmodule // apsr_rate_gen
`default_nettype wire

// ### rtl/apsr_regs.vh
`ifndef APSR_REGS_VH
`define APSR_REGS_VH
// ****************************************************************
// register byte offsets on the direct address port
// ****************************************************************
`define APSR_OFS_CIRC_STEP      8'h0C
`define APSR_OFS_CIRC_STEP_CNT  8'h08
`define APSR_OFS_SDC            8'h24
`define APSR_OFS_LIVE           8'h28
`define APSR_OFS_REMAIN         8'h2C
`define APSR_OFS_CENTRE         8'h9C
`define APSR_OFS_SLOWDOWN       8'hA4
`define APSR_OFS_FEED           8'hBC
`define APSR_OFS_CIRC_STEP_PRE  8'hC4
`define APSR_OFS_CENTRE_PRE     8'hD4
`define APSR_OFS_SLOWDOWN_PRE   8'hDC
`define APSR_OFS_FEED_PRE       8'hF4
// ****************************************************************
// live_speed_and_counts field positions
// ****************************************************************
`define APSR_SPD_MSB            15
`define APSR_SPD_LSB            0
`define APSR_IDX_MSB            19
`define APSR_IDX_LSB            16
`define APSR_IDLE_MSB           22
`define APSR_IDLE_LSB           20
`define APSR_OFFSET_SIGN        23
// ****************************************************************
// reset values and timing
// ****************************************************************
`define APSR_RST_WORD           32'h0000_0000
`define APSR_ACC_FULL_BITS      16
`endif

// ### rtl/apsr_slowdown_cmp.v
`timescale 1ns/1ns
`default_nettype none
`include "apsr_regs.vh"
// slow-down point calculation and deceleration decision
module apsr_slowdown_cmp (
  input  wire        manual_sel,
  input  wire [31:0] slowdown,
  input  wire [31:0] auto_point,
  input  wire [31:0] remaining,
  input  wire        active,
  output wire [31:0] calc_value,
  output wire        decel_now
);
  wire signed [32:0] offs;
  wire signed [32:0] auto_sum;
  wire signed [32:0] calc_s;

  // offset is a 24-bit signed value, sign taken from bit 23
  assign offs     = {{9{slowdown[`APSR_OFFSET_SIGN]}}, slowdown[23:0]};
  assign auto_sum = $signed({1'b0, auto_point}) + offs;
  assign calc_s   = manual_sel ? $signed({1'b0, slowdown}) : auto_sum;
  // negative results clamp to zero: the run ends without decelerating
  assign calc_value = calc_s[32] ? 32'h0000_0000 : calc_s[31:0];
  assign decel_now  = active && (remaining <= calc_value);
endmodule // apsr_slowdown_cmp
`default_nettype wire

// ### test/apsr_axis_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "apsr_regs.vh"
// *********************************
// port checker of the axis block
// *********************************
module apsr_axis_monitor (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata_r,
  input wire logic [15:0] high_speed_step,
  input wire logic        pulser_mode,
  input wire logic        correction_run,
  input wire logic        start_req,
  input wire logic        correction_pulse_r,
  input wire logic        busy_r,
  input wire logic        decel_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // address classes of the register port
  wire live_rd = rd_en && addr == `APSR_OFS_LIVE;
  wire pre_a   = addr == `APSR_OFS_CIRC_STEP_PRE ||
                 addr == `APSR_OFS_CENTRE_PRE ||
                 addr == `APSR_OFS_SLOWDOWN_PRE || addr == `APSR_OFS_FEED_PRE;
  wire live_a  = addr == `APSR_OFS_CIRC_STEP || addr == `APSR_OFS_CENTRE ||
                 addr == `APSR_OFS_SLOWDOWN;
  // write then read of the same word, no start in between
  sequence s_wr_rd(sel);
    wr_en && sel && !start_req ##1 rd_en && !start_req && $stable(addr);
  endsequence
  property p_live_hi; live_rd |=> rdata_r[31:23] == 9'h000; endproperty
  a_live_hi: assert property (p_live_hi)
    else $error("live word high bits not zero");
  property p_feed;
    s_wr_rd(addr == `APSR_OFS_FEED) |=> rdata_r == $past(wdata, 2);
  endproperty
  a_feed: assert property (p_feed)
    else $error("feed word readback differs");
  property p_pre; s_wr_rd(pre_a) |=> rdata_r == $past(wdata, 2); endproperty
  a_pre: assert property (p_pre)
    else $error("pre-register readback differs");
  property p_live_rw; s_wr_rd(live_a) |=> rdata_r == $past(wdata, 2);
  endproperty
  a_live_rw: assert property (p_live_rw)
    else $error("position register readback differs");
  property p_stop_spd; live_rd && !busy_r |=> rdata_r[15:0] == 16'h0000;
  endproperty
  a_stop_spd: assert property (p_stop_spd)
    else $error("speed field not zero while stopped");
  property p_pulser;
    live_rd && busy_r && pulser_mode |=>
      rdata_r[15:0] == $past(high_speed_step);
  endproperty
  a_pulser: assert property (p_pulser)
    else $error("pulser speed field not high step");
  property p_corr_off; !correction_run [*3] |-> !correction_pulse_r;
  endproperty
  a_corr_off: assert property (p_corr_off)
    else $error("correction pulse while disabled");
  property p_decel_busy; decel_r |-> busy_r; endproperty
  a_decel_busy: assert property (p_decel_busy)
    else $error("decelerating while idle");
  property p_decel_end; $fell(decel_r) |-> !busy_r; endproperty
  a_decel_end: assert property (p_decel_end)
    else $error("deceleration ended before motion end");
  // main scenarios reached
  c_decel: cover property ($rose(decel_r));
  c_pulser: cover property (live_rd && busy_r && pulser_mode);
  c_corr: cover property (correction_pulse_r);
endmodule // apsr_axis_monitor

bind apsr_axis apsr_axis_monitor apsr_axis_monitor_i (
  .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata_r),
  .high_speed_step(high_speed_step), .pulser_mode(pulser_mode),
  .correction_run(correction_run), .start_req(start_req),
  .correction_pulse_r(correction_pulse_r), .busy_r(busy_r),
  .decel_r(decel_r)
);
`default_nettype wire

// ### test/apsr_axis_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "apsr_regs.vh"
// *********************************
// bench of the axis block
// *********************************
module apsr_axis_tb;
  logic        clk_sys, srst, wr_en, rd_en, slow_man, pulser, circ, lin2;
  logic        corr_run, start_req, stop_req, idx_in, pulse_out, corr_pulse;
  logic        busy, decel;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [15:0] corr_step, hi_step, lo_step, steps, base, mid;
  logic [11:0] mag;
  logic [3:0]  idx_set;
  logic [2:0]  idle_set;
  int          n_fail, check_count, cyc, n;
  logic [7:0]  map [14] = '{8'h0C, 8'h9C, 8'hA4, 8'hBC, 8'hC4, 8'hD4, 8'hDC,
                           8'hF4, 8'h28, 8'h24, 8'h2C, 8'h08, 8'h00, 8'h40};
  apsr_axis apsr_axis_i (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata_r(rdata),
    .correction_speed_step(corr_step), .speed_magnification_setting(mag),
    .high_speed_step(hi_step), .low_speed_step(lo_step),
    .index_count_setting(idx_set), .idle_count_setting(idle_set),
    .slowdown_manual_select(slow_man), .pulser_mode(pulser),
    .circular_mode(circ), .linear2_mode(lin2), .correction_run(corr_run),
    .start_req(start_req), .stop_req(stop_req),
    .encoder_index_input(idx_in), .pulse_out_r(pulse_out),
    .correction_pulse_r(corr_pulse), .busy_r(busy), .decel_r(decel));
  apsr_drive_model apsr_drive_model_i (.clk_sys(clk_sys), .srst(srst),
    .step_in(pulse_out), .step_cnt(steps), .index_out(idx_in));
  // bus cycles and comparison
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr = a;
    rd_en = 1'b1;
    wait_n(1);
    d = rdata;
    rd_en = 1'b0;
    wait_n(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit rb);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    wait_n(1);
    wr_en = 1'b0;
    if (rb) begin
      rd(a, q);
      chk("readback", d, q);
    end else
      wait_n(1);
  endtask
  // one positioning run of 20 pulses, af pulses after decel start
  task automatic run(input logic m, p, l, c, input logic [31:0] sd,
                     input logic [15:0] af);
    slow_man = m;
    pulser = p;
    lin2 = l;
    circ = c;
    wr(l ? 8'hD4 : 8'hF4, 32'h0000_0014, 0);
    wr(l ? 8'hF4 : 8'hD4, 32'h0000_0000, 0);
    wr(8'hC4, 32'h0000_0014, 0);
    wr(8'hDC, sd, 0);
    base = steps;
    start_req = 1'b1;
    wait_n(1);
    start_req = 1'b0;
    rd(`APSR_OFS_LIVE, q);
    chk("live", {9'h000, idle_set, idx_set, p ? hi_step : lo_step}, q);
    n = 0;
    while (decel !== 1'b1 && n < 2000) begin
      wait_n(1);
      n++;
    end
    wait_n(2);
    mid = steps - base;
    while (busy !== 1'b0 && n < 4000) begin
      wait_n(1);
      n++;
    end
    wait_n(2);
    chk("steps", 32'h0000_0014, {16'h0000, steps - base});
    chk("decel point", {16'h0000, 16'h0014 - af}, {16'h0000, mid});
    rd(c ? `APSR_OFS_CIRC_STEP_CNT : `APSR_OFS_REMAIN, q);
    chk("remaining", 32'h0000_0000, q);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // clock and run-time ceiling
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      final_report;
    end
  end
  // main sequence
  initial begin
    {srst, wr_en, rd_en, slow_man, pulser, circ, lin2} = 7'h7F & 7'h40;
    {corr_run, start_req, stop_req} = 3'h0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    corr_step = 16'h2000;
    lo_step = 16'h4000;
    hi_step = 16'h4004;
    mag = 12'h000;
    idx_set = 4'h4;
    idle_set = 3'h3;
    wait_n(3);
    srst = 1'b0;
    for (int i = 0; i < 14; i++) begin
      rd(map[i], q);
      chk("reset value", 32'h0000_0000, q);
    end
    for (int i = 8; i < 14; i++) begin
      wr(map[i], 32'hFFFF_FFFF, 1'b0);
      rd(map[i], q);
      chk("read only", 32'h0000_0000, q);
    end
    for (int i = 0; i < 8; i++) wr(map[i], 32'h8000_0000 | map[i], 1);
    wr(`APSR_OFS_FEED, 32'h7FFF_FFFF, 1'b1);
    wr(`APSR_OFS_CIRC_STEP, 32'hFFFF_FFFF, 1'b1);
    // manual and automatic points follow the advised formulas with both rates zero
    run(1, 1, 0, 0, 32'h0000_0009, 16'h0009);
    idle_set = 3'h0;
    run(0, 0, 0, 0, 32'h0000_0003, 16'h0007);
    run(0, 0, 0, 0, 32'hFFFF_FFFE, 16'h0002);
    run(1, 0, 1, 0, 32'h0000_0004, 16'h0004);
    run(1, 0, 0, 1, 32'h0000_0008, 16'h0008);
    // a further start, cut short by a stop request
    start_req = 1'b1;
    wait_n(1);
    start_req = 1'b0;
    wait_n(8);
    stop_req = 1'b1;
    wait_n(1);
    stop_req = 1'b0;
    wait_n(1);
    chk("busy after stop", 32'h0000_0000, {31'h0, busy});
    rd(`APSR_OFS_LIVE, q);
    chk("speed after stop", 32'h0000_0000, {16'h0000, q[15:0]});
    for (int m = 0; m < 2; m++) begin
      mag = m[11:0];
      n = 0;
      corr_run = 1'b1;
      repeat (800) begin
        wait_n(1);
        if (corr_pulse === 1'b1) n++;
      end
      corr_run = 1'b0;
      wait_n(4);
      chk("correction pulses", 32'h0000_0001,
          {31'h0, n >= 100 / (m + 1) - 2 && n <= 100 / (m + 1)});
    end
    final_report;
  end
endmodule // apsr_axis_tb
`default_nettype wire

// ### test/apsr_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// *********************************
// motor driver with encoder model
// *********************************
module apsr_drive_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        step_in,
  output var  logic [15:0] step_cnt,
  output var  logic        index_out
);
  // counts steps, one index pulse every fourth step
  always @(posedge clk_sys) begin
    if (srst) begin
      step_cnt  <= 16'h0000;
      index_out <= 1'b0;
    end else begin
      step_cnt  <= step_cnt + {15'h0000, step_in};
      index_out <= step_in && step_cnt[1:0] == 2'h3;
    end
  end
endmodule // apsr_drive_model
`default_nettype wire
